// >>> include/vbs_map.vh
// register offsets, field positions and reset values of the byte stack
`ifndef VBS_MAP_VH
`define VBS_MAP_VH
`define VBS_DEPTH 512
`define VBS_FULL_PTR 10'h200
`define VBS_LEG_PORT 24'h001380
`define VBS_LEG_CTRL 24'h001384
`define VBS_LEG_CFG 24'h001388
`define VBS_LEG_PTR 24'h00138C
`define VBS_NEW_PORT 24'h619E40
`define VBS_NEW_CTRL 24'h619E44
`define VBS_NEW_CFG 24'h619E48
`define VBS_NEW_PTR 24'h619E4C
`define VBS_LEG_CR_PORT 8'h90
`define VBS_LEG_CR_CTRL 8'h91
`define VBS_NEW_CR_PORT 8'hA2
`define VBS_NEW_CR_CTRL 8'hA3
`define VBS_CTRL_PUSH 0
`define VBS_CTRL_POP 1
`define VBS_CTRL_EMPTY 4
`define VBS_CTRL_FULL 5
`define VBS_CTRL_OVF 6
`define VBS_CTRL_UNF 7
`define VBS_CFG_PUSH_AUTO 0
`define VBS_CFG_POP_AUTO 1
`define VBS_CFG_READ_POP 2
`define VBS_CFG_OVF_CLR 6
`define VBS_CFG_UNF_CLR 7
`define VBS_PTR_RESET 10'h000
`define VBS_CFG_RESET 3'h0
`endif

// >>> core/vbs_ram.v
// byte-wide single-port stack storage with registered read data
`timescale 1ns/1ps
module vbs_ram #(
	parameter DEPTH = 512,
	parameter AW = 9
) (
	// clocking
	input wire clk_sys,
	input wire ce,
	// access
	input wire we,
	input wire [AW-1:0] addr,
	input wire [7:0] wdata,
	output reg [7:0] rdata
);
	reg [7:0] mem [0:DEPTH-1];

	// no reset on the array so it maps to block ram
	always @(posedge clk_sys)
	begin
		if (ce)
		begin
			if (we)
				mem[addr] <= wdata;
			rdata <= mem[addr];
		end
	end
endmodule

// >>> core/vbs_dec.v
// address decoder: memory-mapped and crtc index aliases onto register selects
`timescale 1ns/1ps
`include "vbs_map.vh"
module vbs_dec #(
	parameter LATER = 0
) (
	// bus address and space
	input wire [23:0] addr,
	input wire cr_space,
	// selects
	output reg sel_port,
	output reg sel_ctrl,
	output reg sel_cfg,
	output reg sel_ptr
);
	// crtc space reaches only port and control
	always @*
	begin
		sel_port = 1'b0;
		sel_ctrl = 1'b0;
		sel_cfg = 1'b0;
		sel_ptr = 1'b0;
		if (cr_space)
		begin
			sel_port = addr[7:0] == (LATER ? `VBS_NEW_CR_PORT : `VBS_LEG_CR_PORT);
			sel_ctrl = addr[7:0] == (LATER ? `VBS_NEW_CR_CTRL : `VBS_LEG_CR_CTRL);
		end
		else
		begin
			sel_port = addr == (LATER ? `VBS_NEW_PORT : `VBS_LEG_PORT);
			sel_ctrl = addr == (LATER ? `VBS_NEW_CTRL : `VBS_LEG_CTRL);
			sel_cfg = addr == (LATER ? `VBS_NEW_CFG : `VBS_LEG_CFG);
			sel_ptr = addr == (LATER ? `VBS_NEW_PTR : `VBS_LEG_PTR);
		end
	end
endmodule

// >>> core/vbs_stack.v
// byte stack core: registers, push/pop engine, error flags
// Function
// - storage of 512 one-byte cells used as a LIFO stack
// - stack pointer is ten bits wide
// - stack grows upward; pointer names next push cell; push increments
// - pointer 0 is empty, 512 is full
// - array accesses at 512 or above wrap modulo 512
// - separate auto/manual selection for push and for pop
// - auto mode: port write pushes, port read pops
// - only low eight bits of a port write are kept
// - manual read returns next-pop byte or last-popped byte per ordering
// - legacy: port write when full or port read when empty flagged but access still done, pointer wraps
// - later: overflowing push or underflowing pop flagged and discarded
// - flags sticky; legacy clears only via setup clear bits
// - later: pop without a push clears overflow; push clears underflow unless a pop underflows with it
// - later: write shadow and read shadow bytes held
// - control bit 0 pushes, bit 1 pops; both read zero
// - control bit 4 empty, bit 5 full, read-only
// - control bits 6, 7 show overflow, underflow; writes ignored
// - port and control aliased in crtc index space
// - setup bit 0 push mode, bit 1 pop mode, bit 2 pop ordering
// - legacy setup bits 6, 7 clear flags and read zero
// - pointer register holds low ten bits, acts directly on pointer
`timescale 1ns/1ps
`include "vbs_map.vh"
module vbs_stack #(
	parameter LATER = 0,
	parameter DEPTH = 512,
	parameter AW = 9
) (
	// clock, enable, reset
	input wire clk_sys,
	input wire ce,
	input wire resetn,
	// register access
	input wire [23:0] addr,
	input wire cr_space,
	input wire wr_en,
	input wire rd_en,
	input wire [31:0] wdata,
	output reg [31:0] rdata_q,
	output reg rvalid_q
);
	// state
	reg [9:0] sp_q;
	reg ovf_q;
	reg unf_q;
	reg [2:0] cfg_q;
	reg [7:0] wshadow_q;
	reg [7:0] rshadow_q;
	reg [7:0] lastw_q;
	// a later-variant pop with no push in the same cycle that really moved the pointer refreshes the shadow
	reg pop_fill_q;
	// pending read: answer comes one cycle after ram lookup
	reg rd_pend_q;
	reg [1:0] rd_kind_q;
	reg [31:0] rd_hold_q;

	wire sel_port;
	wire sel_ctrl;
	wire sel_cfg;
	wire sel_ptr;
	wire [7:0] ram_q;

	vbs_dec #(.LATER(LATER)) u_dec (
		.addr(addr),
		.cr_space(cr_space),
		.sel_port(sel_port),
		.sel_ctrl(sel_ctrl),
		.sel_cfg(sel_cfg),
		.sel_ptr(sel_ptr)
	);

	// operation decode for this access
	wire port_wr = wr_en & sel_port;
	wire port_rd = rd_en & sel_port & ~wr_en;
	wire trig_push = wr_en & sel_ctrl & wdata[`VBS_CTRL_PUSH];
	wire trig_pop = wr_en & sel_ctrl & wdata[`VBS_CTRL_POP];
	wire do_push = trig_push | (port_wr & cfg_q[`VBS_CFG_PUSH_AUTO]);
	wire do_pop = trig_pop | (port_rd & cfg_q[`VBS_CFG_POP_AUTO]);
	wire is_empty = sp_q == 10'h000;
	wire is_full = sp_q >= `VBS_FULL_PTR;
	wire [9:0] sp_dec = sp_q - 10'h001;
	// an auto push in the later variant must use the byte arriving now, not the old shadow
	wire [7:0] push_byte = (port_wr | ~LATER) ? wdata[7:0] : wshadow_q;
	// legacy port write stores the byte at sp; a manual push only moves the pointer
	wire leg_store = ~LATER & port_wr;
	wire new_store = LATER & do_push & ~is_full;
	wire ram_we = leg_store | new_store;
	// read address: pop/read target is sp-1 except a legacy non-popping port read with ordering bit clear, which uses sp; write target is sp; low bits wrap
	reg [AW-1:0] ram_addr;

	always @*
	begin
		if (ram_we)
			ram_addr = sp_q[AW-1:0];
		else if (do_pop)
			ram_addr = sp_dec[AW-1:0];
		else if (port_rd & ~LATER & ~cfg_q[`VBS_CFG_READ_POP])
			ram_addr = sp_q[AW-1:0];
		else
			ram_addr = sp_dec[AW-1:0];
	end

	vbs_ram #(.DEPTH(DEPTH), .AW(AW)) u_ram (
		.clk_sys(clk_sys),
		.ce(ce),
		.we(ram_we),
		.addr(ram_addr),
		.wdata(push_byte),
		.rdata(ram_q)
	);

	// register read mux for non-port registers
	reg [31:0] reg_rd;

	always @*
	begin
		reg_rd = 32'h00000000;
		if (sel_ctrl)
		begin
			reg_rd[`VBS_CTRL_EMPTY] = is_empty;
			reg_rd[`VBS_CTRL_FULL] = is_full;
			reg_rd[`VBS_CTRL_OVF] = ovf_q;
			reg_rd[`VBS_CTRL_UNF] = unf_q;
		end
		else if (sel_cfg)
			reg_rd[2:0] = cfg_q;
		else if (sel_ptr)
			reg_rd[9:0] = sp_q;
	end

	// read kinds: 0 register, 1 ram, 2 read shadow
	reg [1:0] kind_d;

	always @*
	begin
		kind_d = 2'h0;
		if (port_rd)
		begin
			if (LATER)
			begin
				// an auto pop answers with the ram byte it removes; the shadow lags a cycle
				if ((~cfg_q[`VBS_CFG_POP_AUTO] & ~cfg_q[`VBS_CFG_READ_POP]) | is_empty)
					kind_d = 2'h2;
				else
					kind_d = 2'h1;
			end
			else
				kind_d = 2'h1;
		end
	end

	// main state update
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			sp_q <= `VBS_PTR_RESET;
			ovf_q <= 1'b0;
			unf_q <= 1'b0;
			cfg_q <= `VBS_CFG_RESET;
			wshadow_q <= 8'h00;
			rshadow_q <= 8'h00;
			lastw_q <= 8'h00;
			rd_pend_q <= 1'b0;
			rd_kind_q <= 2'h0;
			rd_hold_q <= 32'h00000000;
			rdata_q <= 32'h00000000;
			rvalid_q <= 1'b0;
		end
		else if (ce)
		begin
			// port write captures the byte
			if (port_wr)
			begin
				lastw_q <= wdata[7:0];
				if (LATER)
					wshadow_q <= wdata[7:0];
			end
			// setup register and legacy clear strobes
			if (wr_en & sel_cfg)
				cfg_q <= wdata[2:0];
			if (LATER)
			begin
				// later variant: discard offending access, cross-clear flags
				if (do_push)
				begin
					if (is_full)
						ovf_q <= 1'b1;
					else
						sp_q <= sp_q + 10'h001;
					unf_q <= 1'b0;
				end
				if (do_pop)
				begin
					if (is_empty)
						unf_q <= 1'b1;
					else
						sp_q <= sp_dec;
					if (~do_push)
						ovf_q <= 1'b0;
				end
				if (do_push & do_pop & is_full)
					ovf_q <= 1'b1;
				if (do_push & do_pop & ~is_full & ~is_empty)
					sp_q <= sp_q;
			end
			else
			begin
				// legacy: flag but still execute; set beats clear
				if (wr_en & sel_cfg & wdata[`VBS_CFG_OVF_CLR])
					ovf_q <= 1'b0;
				if (wr_en & sel_cfg & wdata[`VBS_CFG_UNF_CLR])
					unf_q <= 1'b0;
				if (port_wr & is_full)
					ovf_q <= 1'b1;
				if (port_rd & is_empty)
					unf_q <= 1'b1;
				if (do_push & ~do_pop)
					sp_q <= sp_q + 10'h001;
				else if (do_pop & ~do_push)
					sp_q <= sp_dec;
			end
			// direct pointer write wins over stack motion
			if (wr_en & sel_ptr)
				sp_q <= wdata[9:0];
			// read pipeline: ram data lands next cycle
			rd_pend_q <= rd_en;
			rd_kind_q <= kind_d;
			rd_hold_q <= reg_rd;
			rvalid_q <= rd_pend_q;
			if (rd_pend_q)
			begin
				if (rd_kind_q == 2'h1)
					rdata_q <= {24'h000000, ram_q};
				else if (rd_kind_q == 2'h2)
					rdata_q <= {24'h000000, rshadow_q};
				else
					rdata_q <= rd_hold_q;
			end
			// later variant pop result fills the read shadow from ram
			if (LATER & pop_fill_q)
				rshadow_q <= ram_q;
		end
	end

	// shadow refresh strobe, one cycle behind the pop that read the ram
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			pop_fill_q <= 1'b0;
		else if (ce)
			pop_fill_q <= do_pop & ~is_empty & ~do_push & ~ram_we;
	end
endmodule

// >>> tb/vbs_stack_asserts.sv
// port-level checker for the byte stack register interface
`timescale 1ns/1ps
`include "vbs_map.vh"
module vbs_asserts #(
	parameter LATER = 0
) (
	// clock and reset
	input wire clk_sys,
	input wire ce,
	input wire resetn,
	// register access
	input wire [23:0] addr,
	input wire cr_space,
	input wire wr_en,
	input wire rd_en,
	input wire [31:0] wdata,
	input wire [31:0] rdata_q,
	input wire rvalid_q
);
	wire rd = ce && rd_en && !wr_en;
	wire [23:0] off = addr - (LATER ? `VBS_NEW_PORT : `VBS_LEG_PORT);
	wire [7:0] cri = addr[7:0] - (LATER ? `VBS_NEW_CR_PORT : `VBS_LEG_CR_PORT);
	reg [2:0] kind_d;
	reg [2:0] k1_q, k2_q, k3_q;
	// answer lands two or three edges on, so take the older kind only when the younger is idle
	wire [2:0] kv = (k2_q != 3'h7) ? k2_q : k3_q;

	// kind of a taken read: 0 port, 1 control, 2 setup, 3 pointer, 4 unmapped, 7 none
	always @*
	begin
		kind_d = 3'h7;
		if (rd && cr_space)
			kind_d = (cri < 8'h02) ? {2'h0, cri[0]} : 3'h4;
		else if (rd)
			kind_d = (off < 24'h000010 && off[1:0] == 2'h0) ? {1'h0, off[3:2]} : 3'h4;
	end

	// short history, long enough to pair each answer with its read
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			k1_q <= 3'h7;
			k2_q <= 3'h7;
			k3_q <= 3'h7;
		end
		else
		begin
			k1_q <= kind_d;
			k2_q <= k1_q;
			k3_q <= k2_q;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence s_read;
		rd;
	endsequence
	sequence s_answer;
		##[2:3] rvalid_q;
	endsequence

	a_read_answer: assert property (s_read |-> s_answer) else $error("read got no answer");
	a_answer_cause: assert property (rvalid_q |-> $past(rd, 2) || $past(rd, 3)) else $error("answer without read");
	a_port_byte: assert property (rvalid_q && kv == 3'h0 |-> rdata_q[31:8] == 24'h000000)
		else $error("port read wider than a byte");
	a_trig_zero: assert property (rvalid_q && kv == 3'h1 |-> rdata_q[1:0] == 2'h0)
		else $error("trigger bits read nonzero");
	a_empty_full: assert property (rvalid_q && kv == 3'h1 |-> !(rdata_q[4] && rdata_q[5]))
		else $error("empty and full together");
	a_clear_bits_zero: assert property (rvalid_q && kv == 3'h2 |-> LATER != 0 || rdata_q[7:6] == 2'h0)
		else $error("clear bits read nonzero");
	a_ptr_ten_bits: assert property (rvalid_q && kv == 3'h3 |-> rdata_q[31:10] == 22'h000000)
		else $error("pointer wider than ten bits");
	a_unmapped_zero: assert property (rvalid_q && kv == 3'h4 |-> rdata_q == 32'h00000000)
		else $error("unmapped read nonzero");
endmodule

bind vbs_stack vbs_asserts #(.LATER(LATER)) u_chk (.clk_sys(clk_sys), .ce(ce), .resetn(resetn), .addr(addr),
	.cr_space(cr_space), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata_q(rdata_q), .rvalid_q(rvalid_q));

// >>> tb/tb_vbs_stack.sv
// self-checking bench for the byte stack, legacy variant
`timescale 1ns/1ps
`include "vbs_map.vh"
module tb_vbs_stack;
	reg clk_sys = 0, ce = 1, resetn = 0, cr_space = 0, wr_en = 0, rd_en = 0;
	reg [23:0] addr = 0;
	reg [31:0] wdata = 0, r;
	wire [31:0] rdata_q;
	wire rvalid_q;
	integer seed = 70, n_mismatch = 0, checks_done = 0, i;
	reg [7:0] b [0:5];
	localparam [24:0] P = {1'h0, `VBS_LEG_PORT}, C = {1'h0, `VBS_LEG_CTRL}, G = {1'h0, `VBS_LEG_CFG};
	localparam [24:0] S = {1'h0, `VBS_LEG_PTR}, XC = {17'h10000, `VBS_LEG_CR_CTRL}, U = 25'h0013A0;

	vbs_stack #(.LATER(0)) uut (.clk_sys(clk_sys), .ce(ce), .resetn(resetn), .addr(addr), .cr_space(cr_space),
		.wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata_q(rdata_q), .rvalid_q(rvalid_q));

	always #25 clk_sys = ~clk_sys;

	// expected status byte; trigger bits never read back
	function [31:0] st(input [9:0] sp, input ov, input un);
		st = {24'h000000, un, ov, sp >= 10'h200, sp == 10'h000, 4'h0};
	endfunction

	task chk(input [31:0] got, input [31:0] exp);
	begin
		checks_done = checks_done + 1;
		if (got !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask

	task end_sim;
	begin
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask

	// one-cycle write strobe, launched at the falling edge
	task wr(input [24:0] a, input [31:0] d);
	begin
		@(negedge clk_sys);
		{cr_space, addr} = a;
		wdata = d;
		wr_en = 1;
		@(negedge clk_sys);
		wr_en = 0;
	end
	endtask

	// read and wait a bounded time for the answer; the gap also covers the pop-to-read spacing
	task rd(input [24:0] a, input [31:0] e);
		integer k;
	begin
		@(negedge clk_sys);
		{cr_space, addr} = a;
		rd_en = 1;
		@(negedge clk_sys);
		rd_en = 0;
		k = 0;
		while (rvalid_q !== 1'b1 && k < 8)
		begin
			@(negedge clk_sys);
			k = k + 1;
		end
		chk({31'h0, rvalid_q}, 32'h1);
		chk(rdata_q, e);
		@(negedge clk_sys);
	end
	endtask

	initial
	begin
		#200000;
		n_mismatch = n_mismatch + 1;
		end_sim;
	end

	initial
	begin
		repeat (5) @(negedge clk_sys);
		resetn = 1;
		rd(C, st(10'h000, 0, 0));
		rd(S, 32'h0);
		wr(G, 32'h3);
		for (i = 0; i < 6; i = i + 1)
		begin
			b[i] = $random(seed);
			r = $random(seed);
			wr(P, {r[23:0], b[i]});
		end
		rd(S, 32'h6);
		for (i = 5; i >= 0; i = i - 1)
			rd(P, {24'h0, b[i]});
		wr(S, 32'h1FF);
		wr(P, 32'hFFFF_FF3C);
		rd(C, st(10'h200, 0, 0));
		wr(S, 32'h0);
		rd(P, 32'h3C);
		rd(C, st(10'h3FF, 0, 1));
		rd(S, 32'h3FF);
		wr(G, 32'h83);
		rd(G, 32'h3);
		rd(C, st(10'h3FF, 0, 0));
		wr(P, 32'hC3);
		rd(C, st(10'h000, 1, 0));
		wr(G, 32'h4);
		wr(S, 32'h200);
		wr(P, 32'h5A);
		wr(C, 32'h1);
		rd(P, 32'h5A);
		wr(C, 32'h2);
		rd(S, 32'h200);
		rd(XC, st(10'h200, 1, 0));
		wr(XC, 32'h2);
		wr(G, 32'h40);
		rd(C, st(10'h1FF, 0, 0));
		rd(P, 32'hC3);
		wr(C, 32'hF0);
		rd(C, st(10'h1FF, 0, 0));
		rd(U, 32'h0);
		// clock enable low: a pointer write must not land
		ce = 0;
		wr(S, 32'h77);
		ce = 1;
		rd(S, 32'h1FF);
		end_sim;
	end
endmodule
